//--- src/tcu_defs.svh
// register indices, field positions, reset values of the timer/counter unit
`ifndef TCU_DEFS_SVH
`define TCU_DEFS_SVH

// ==============================================================
// register indices (byte address is four times the index)
`define IDX_TIMERS01_CONTROL   8'h88
`define IDX_TIMERS01_MODE      8'h89
`define IDX_TIMER0_LOW         8'h8A
`define IDX_TIMER1_LOW         8'h8B
`define IDX_TIMER0_HIGH        8'h8C
`define IDX_TIMER1_HIGH        8'h8D
`define IDX_TIMER2_CONTROL     8'hC8
`define IDX_TIMER2_RELOAD_LOW  8'hCA
`define IDX_TIMER2_RELOAD_HIGH 8'hCB
`define IDX_TIMER2_LOW         8'hCC
`define IDX_TIMER2_HIGH        8'hCD

// ==============================================================
// timer 2 control fields
`define T2C_OVF_FLAG   7
`define T2C_EXT_FLAG   6
`define T2C_RX_CLK     5
`define T2C_TX_CLK     4
`define T2C_EXT_EN     3
`define T2C_RUN        2
`define T2C_COUNT_SRC  1
`define T2C_CAPTURE    0

// ==============================================================
// timers 0/1 control fields
`define TC_T1_FLAG     7
`define TC_T1_RUN      6
`define TC_T0_FLAG     5
`define TC_T0_RUN      4

// mode register: one nibble per timer, timer 1 in the upper nibble
`define TM_NIBBLE      4
`define TM_GATE        3
`define TM_COUNT_SRC   2
`define TM_MODE_HI     1
`define TM_MODE_LO     0

// ==============================================================
// reset values and constants
`define RST_BYTE       8'h00
`define RST_WORD       16'h0000
`define ALL_ONES_WORD  16'hFFFF
`define ALL_ONES_BYTE  8'hFF
`define LOW5_ALL_ONES  5'h1F

`endif

//--- src/tcu_pkg.sv
// types shared by the timer/counter unit
`default_nettype none
package tcu_pkg;

    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    // external count, gate and trigger pins
    typedef struct packed {
        logic extInterruptOnePin;
        logic extInterruptZeroPin;
        logic timer2ExternalTriggerPin;
        logic timer2CountInputPin;
        logic countPin1;
        logic countPin0;
    } timer_pins_type;

    // timer 0/1 mode encodings
    typedef enum logic [1:0] {
        MODE_13BIT = 2'h0,
        MODE_16BIT = 2'h1,
        MODE_RELOAD8 = 2'h2,
        MODE_SPLIT = 2'h3
    } timer_mode_type;

    // whole state of the unit
    typedef struct packed {
        logic [15:0] timer0Count;
        logic [15:0] timer1Count;
        logic [15:0] timer2Count;
        logic [15:0] timer2Reload;
        logic [7:0]  timer2Control;
        logic [7:0]  modeReg;
        logic        timer1Flag;
        logic        timer1Run;
        logic        timer0Flag;
        logic        timer0Run;
        logic        ready;
        logic        slvErr;
        logic [31:0] readData;
    } tcu_state_type;

endpackage
`default_nettype wire

//--- src/pin_fall_detect.sv
// falling-edge detector for a group of synchronous pins
`default_nettype none
module pin_fall_detect #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             clkEn,
    // pins and edges
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] prev_reg;
    logic [WIDTH-1:0] prev_next;

    // ==========================================================
    // elaboration check
    if (WIDTH < 1) begin : g_width_check
        $error("pin_fall_detect needs at least one pin");
    end

    // last sampled level, held while the clock enable is low
    always_comb begin
        prev_next = clkEn ? pins : prev_reg;
    end

    // reset to low so no false edge follows reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= prev_next;
        end
    end

    // high-to-low seen this cycle
    assign fall = prev_reg & ~pins;

endmodule // pin_fall_detect
`default_nettype wire

//--- src/timer_counter_unit.sv
// three-channel timer/counter unit with an apb register slave
//
// Contract
// - trigger pin falling edge captures or reloads only when enabled and not baud
// - timer 2 counts only while its run bit is set
// - timer 2 counts input pin edges when source bit set, else clocks
// - capture select plus trigger enable: trigger edge captures the timer 2 count
// - capture select clear: reload on overflow, and on enabled trigger edges
// - any serial clock select forces reload on overflow, capture select ignored
// - timers 0 and 1 each have high and low byte registers
// - timers 0 and 1 share identical mode behaviour unless stated
// - timer mode advances once per core clock, no prescaler
// - mode 0 counts 13 bits: high byte plus low five bits of low byte
// - mode 0 upper three low-byte bits are undefined to software
// - wrap from all ones to zero sets that timer's overflow flag
// - count reaches timer only when run and (gate clear or interrupt pin high)
// - setting a run bit leaves the count registers unchanged
// - mode 1 is mode 0 with all sixteen bits
// - mode 2: low byte counts, overflow sets flag, reloads low from high
// - timer 1 in mode 3 holds its count as if stopped
// - timer 0 mode 3: low byte is independent counter with timer 0 controls
// - timer 0 mode 3: high byte counts core clocks only, never pin edges
// - timer 0 mode 3: high byte runs on timer 1 run bit, sets timer 1 flag
// - trigger-caused capture or reload sets external flag, software clears it
// - timer 2 overflow sets its flag, never while a serial clock select is set
// - capture copies count bytes to capture bytes; reload loads them back
//
// Implementation choice: the APB slave port.
`include "tcu_defs.svh"
`default_nettype none
module timer_counter_unit
    import tcu_pkg::*;
(
    // clock, reset, enable
    input  wire logic           core_clk,
    input  wire logic           reset,
    input  wire logic           clkEn,
    // apb slave
    input  wire apb_req_type    apbReq,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    // external pins
    input  wire timer_pins_type pinsIn,
    // flag levels for the interrupt controller
    output logic                timer0OverflowFlag,
    output logic                timer1OverflowFlag,
    output logic                timer2OverflowFlag,
    output logic                timer2ExternalFlag
);

    tcu_state_type  stateReg;
    tcu_state_type  stateNext;
    logic [3:0]     pinFall;
    logic [1:0]     runBits;
    logic [1:0]     intPins;
    logic [1:0]     countEn;
    timer_mode_type mode0;
    timer_mode_type mode1;
    logic [16:0]    step0;
    logic [16:0]    step1;
    logic           timer1Active;
    logic           highOvf;
    logic           setFlag0;
    logic           setFlag1;
    logic           baudMode;
    logic           count2En;
    logic           ovf2;
    logic           extTrig;
    logic           setFlag2;
    logic           addrOk;
    logic           commit;
    logic           wrCommit;
    logic [7:0]     regIdx;
    logic [7:0]     wrByte;

    // ==========================================================
    // one step of a timer 0/1 count: {overflow, new count}
    function automatic logic [16:0] step_count(input timer_mode_type md,
                                               input logic [15:0] c);
        logic [16:0] r;
        r = {1'b0, c};
        case (md)
            MODE_13BIT: begin
                if (c[4:0] == `LOW5_ALL_ONES) begin
                    r = {c[15:8] == `ALL_ONES_BYTE, c[15:8] + 8'h01, c[7:5], 5'h00};
                end else begin
                    r = {1'b0, c[15:5], c[4:0] + 5'h01};
                end
            end
            MODE_16BIT: begin
                r = {c == `ALL_ONES_WORD, c + 16'h0001};
            end
            MODE_RELOAD8: begin
                if (c[7:0] == `ALL_ONES_BYTE) begin
                    r = {1'b1, c[15:8], c[15:8]};
                end else begin
                    r = {1'b0, c[15:8], c[7:0] + 8'h01};
                end
            end
            default: begin
                r = {c[7:0] == `ALL_ONES_BYTE, c[15:8], c[7:0] + 8'h01};
            end
        endcase
        return r;
    endfunction

    // ==========================================================
    // read decode: {hit, byte}
    function automatic logic [8:0] read_reg(input tcu_state_type s,
                                            input logic [7:0] idx);
        logic [8:0] r;
        r = 9'h000;
        if (idx == `IDX_TIMERS01_CONTROL) begin
            r = {1'b1, s.timer1Flag, s.timer1Run, s.timer0Flag, s.timer0Run, 4'h0};
        end else if (idx == `IDX_TIMERS01_MODE) begin
            r = {1'b1, s.modeReg};
        end else if (idx == `IDX_TIMER0_LOW) begin
            r = {1'b1, s.timer0Count[7:0]};
        end else if (idx == `IDX_TIMER0_HIGH) begin
            r = {1'b1, s.timer0Count[15:8]};
        end else if (idx == `IDX_TIMER1_LOW) begin
            r = {1'b1, s.timer1Count[7:0]};
        end else if (idx == `IDX_TIMER1_HIGH) begin
            r = {1'b1, s.timer1Count[15:8]};
        end else if (idx == `IDX_TIMER2_CONTROL) begin
            r = {1'b1, s.timer2Control};
        end else if (idx == `IDX_TIMER2_RELOAD_LOW) begin
            r = {1'b1, s.timer2Reload[7:0]};
        end else if (idx == `IDX_TIMER2_RELOAD_HIGH) begin
            r = {1'b1, s.timer2Reload[15:8]};
        end else if (idx == `IDX_TIMER2_LOW) begin
            r = {1'b1, s.timer2Count[7:0]};
        end else if (idx == `IDX_TIMER2_HIGH) begin
            r = {1'b1, s.timer2Count[15:8]};
        end
        return r;
    endfunction

    // ==========================================================
    // pin edges
    pin_fall_detect #(
        .WIDTH (4)
    ) u_fall (
        .core_clk (core_clk),
        .reset    (reset),
        .clkEn    (clkEn),
        .pins     ({pinsIn.timer2ExternalTriggerPin, pinsIn.timer2CountInputPin,
                    pinsIn.countPin1, pinsIn.countPin0}),
        .fall     (pinFall)
    );

    // ==========================================================
    // timers 0 and 1: count enables
    assign runBits = {stateReg.timer1Run, stateReg.timer0Run};
    assign intPins = {pinsIn.extInterruptOnePin, pinsIn.extInterruptZeroPin};
    assign mode0 = timer_mode_type'(stateReg.modeReg[1:0]);
    assign mode1 = timer_mode_type'(stateReg.modeReg[5:4]);

    // same gating for both timers
    for (genvar i = 0; i < 2; i++) begin : g_gate
        localparam int B = i * `TM_NIBBLE;
        assign countEn[i] = runBits[i]
                          & (~stateReg.modeReg[B + `TM_GATE] | intPins[i])
                          & (stateReg.modeReg[B + `TM_COUNT_SRC] ? pinFall[i] : 1'b1);
    end

    assign step0 = step_count(mode0, stateReg.timer0Count);
    assign step1 = step_count(mode1, stateReg.timer1Count);
    assign timer1Active = countEn[1] & (mode1 != MODE_SPLIT);
    // split high byte: core clocks, timer 1 run bit
    assign highOvf = (mode0 == MODE_SPLIT) & stateReg.timer1Run
                   & (stateReg.timer0Count[15:8] == `ALL_ONES_BYTE);
    assign setFlag0 = countEn[0] & step0[16];
    assign setFlag1 = (timer1Active & step1[16]) | highOvf;

    // ==========================================================
    // timer 2 conditions
    assign baudMode = stateReg.timer2Control[`T2C_RX_CLK] | stateReg.timer2Control[`T2C_TX_CLK];
    assign count2En = stateReg.timer2Control[`T2C_RUN]
                    & (stateReg.timer2Control[`T2C_COUNT_SRC] ? pinFall[2] : 1'b1);
    assign ovf2 = count2En & (stateReg.timer2Count == `ALL_ONES_WORD);
    assign extTrig = stateReg.timer2Control[`T2C_EXT_EN] & ~baudMode & pinFall[3];
    assign setFlag2 = ovf2 & ~baudMode;

    // ==========================================================
    // bus decode
    assign addrOk = (apbReq.paddr[1:0] == 2'b00) & (apbReq.paddr[11:10] == 2'b00);
    assign regIdx = apbReq.paddr[9:2];
    assign wrByte = apbReq.pwdata[7:0];
    assign commit = apbReq.psel & apbReq.penable & stateReg.ready;
    assign wrCommit = commit & apbReq.pwrite & ~stateReg.slvErr;

    // ==========================================================
    // next state
    always_comb begin
        logic [8:0] rd;
        rd = read_reg(stateReg, regIdx);
        stateNext = stateReg;

        // apb: answer one cycle after setup, data sampled at setup
        stateNext.ready = apbReq.psel & ~apbReq.penable;
        if (apbReq.psel & ~apbReq.penable) begin
            stateNext.slvErr = ~(rd[8] & addrOk);
            stateNext.readData = {24'h0, (rd[8] & addrOk) ? rd[7:0] : 8'h00};
        end

        // timer 0
        if (countEn[0]) begin
            stateNext.timer0Count = step0[15:0];
        end
        if (mode0 == MODE_SPLIT && stateReg.timer1Run) begin
            stateNext.timer0Count[15:8] = stateReg.timer0Count[15:8] + 8'h01;
        end
        // timer 1
        if (timer1Active) begin
            stateNext.timer1Count = step1[15:0];
        end
        stateNext.timer0Flag = stateReg.timer0Flag | setFlag0;
        stateNext.timer1Flag = stateReg.timer1Flag | setFlag1;

        // timer 2 count and reload on overflow
        if (count2En) begin
            if (ovf2 && (baudMode || !stateReg.timer2Control[`T2C_CAPTURE])) begin
                stateNext.timer2Count = stateReg.timer2Reload;
            end else begin
                stateNext.timer2Count = stateReg.timer2Count + 16'h0001;
            end
        end
        // trigger edge: capture or reload
        if (extTrig) begin
            if (stateReg.timer2Control[`T2C_CAPTURE]) begin
                stateNext.timer2Reload = stateReg.timer2Count;
            end else begin
                stateNext.timer2Count = stateReg.timer2Reload;
            end
        end
        stateNext.timer2Control[`T2C_OVF_FLAG] =
            stateReg.timer2Control[`T2C_OVF_FLAG] | setFlag2;
        stateNext.timer2Control[`T2C_EXT_FLAG] =
            stateReg.timer2Control[`T2C_EXT_FLAG] | extTrig;

        // software writes win over counting, hardware sets win over clears
        if (wrCommit) begin
            if (regIdx == `IDX_TIMERS01_CONTROL) begin
                stateNext.timer1Flag = wrByte[`TC_T1_FLAG] | setFlag1;
                stateNext.timer1Run = wrByte[`TC_T1_RUN];
                stateNext.timer0Flag = wrByte[`TC_T0_FLAG] | setFlag0;
                stateNext.timer0Run = wrByte[`TC_T0_RUN];
            end else if (regIdx == `IDX_TIMERS01_MODE) begin
                stateNext.modeReg = wrByte;
            end else if (regIdx == `IDX_TIMER0_LOW) begin
                stateNext.timer0Count[7:0] = wrByte;
            end else if (regIdx == `IDX_TIMER0_HIGH) begin
                stateNext.timer0Count[15:8] = wrByte;
            end else if (regIdx == `IDX_TIMER1_LOW) begin
                stateNext.timer1Count[7:0] = wrByte;
            end else if (regIdx == `IDX_TIMER1_HIGH) begin
                stateNext.timer1Count[15:8] = wrByte;
            end else if (regIdx == `IDX_TIMER2_CONTROL) begin
                stateNext.timer2Control = wrByte;
                stateNext.timer2Control[`T2C_OVF_FLAG] = wrByte[`T2C_OVF_FLAG] | setFlag2;
                stateNext.timer2Control[`T2C_EXT_FLAG] = wrByte[`T2C_EXT_FLAG] | extTrig;
            end else if (regIdx == `IDX_TIMER2_RELOAD_LOW) begin
                stateNext.timer2Reload[7:0] = wrByte;
            end else if (regIdx == `IDX_TIMER2_RELOAD_HIGH) begin
                stateNext.timer2Reload[15:8] = wrByte;
            end else if (regIdx == `IDX_TIMER2_LOW) begin
                stateNext.timer2Count[7:0] = wrByte;
            end else if (regIdx == `IDX_TIMER2_HIGH) begin
                stateNext.timer2Count[15:8] = wrByte;
            end
        end
    end

    // ==========================================================
    // state register, frozen while the clock enable is low
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stateReg <= '0;
        end else if (clkEn) begin
            stateReg <= stateNext;
        end
    end

    // outputs straight from the state register
    assign prdata = stateReg.readData;
    assign pready = stateReg.ready;
    assign pslverr = stateReg.slvErr;
    assign timer0OverflowFlag = stateReg.timer0Flag;
    assign timer1OverflowFlag = stateReg.timer1Flag;
    assign timer2OverflowFlag = stateReg.timer2Control[`T2C_OVF_FLAG];
    assign timer2ExternalFlag = stateReg.timer2Control[`T2C_EXT_FLAG];

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_TRIGGER_IGNORED: assert property (
        clkEn && !stateReg.timer2Control[`T2C_EXT_EN] && !wrCommit
        |=> $stable(stateReg.timer2Reload) && !$rose(timer2ExternalFlag))
        else $error("trigger pin acted while disabled");

    AST_T2_STOPPED: assert property (
        clkEn && !stateReg.timer2Control[`T2C_RUN] && !wrCommit && !extTrig
        |=> $stable(stateReg.timer2Count))
        else $error("timer 2 moved while stopped");

    AST_T2_CLOCK_COUNT: assert property (
        clkEn && stateReg.timer2Control[`T2C_RUN] && !stateReg.timer2Control[`T2C_COUNT_SRC]
        && stateReg.timer2Count != `ALL_ONES_WORD && !extTrig && !wrCommit
        |=> stateReg.timer2Count == $past(stateReg.timer2Count) + 16'h0001)
        else $error("timer 2 missed a core clock");

    AST_T2_CAPTURE: assert property (
        clkEn && extTrig && stateReg.timer2Control[`T2C_CAPTURE] && !wrCommit
        |=> stateReg.timer2Reload == $past(stateReg.timer2Count) && timer2ExternalFlag)
        else $error("capture did not copy the count");

    AST_T2_RELOAD: assert property (
        clkEn && ovf2 && !stateReg.timer2Control[`T2C_CAPTURE] && !extTrig && !wrCommit
        |=> stateReg.timer2Count == $past(stateReg.timer2Reload)
            && (timer2OverflowFlag || $past(baudMode)))
        else $error("overflow did not reload");

    AST_BAUD_NO_FLAG: assert property (
        clkEn && baudMode && !timer2OverflowFlag && !wrCommit |=> !timer2OverflowFlag)
        else $error("overflow flag set in baud mode");

    AST_MODE2_RELOAD: assert property (
        clkEn && mode0 == MODE_RELOAD8 && setFlag0 && !wrCommit
        |=> stateReg.timer0Count[7:0] == $past(stateReg.timer0Count[15:8])
            && $stable(stateReg.timer0Count[15:8]) && timer0OverflowFlag)
        else $error("mode 2 reload wrong");

    AST_T1_SPLIT_HOLD: assert property (
        clkEn && mode1 == MODE_SPLIT && !wrCommit |=> $stable(stateReg.timer1Count))
        else $error("timer 1 moved in mode 3");

    AST_HIGH_SETS_T1: assert property (
        clkEn && highOvf && !wrCommit |=> timer1OverflowFlag
            && stateReg.timer0Count[15:8] == 8'h00)
        else $error("split high byte overflow lost");

    AST_RUN_KEEPS_COUNT: assert property (
        clkEn && !stateReg.timer0Run && !(mode0 == MODE_SPLIT && stateReg.timer1Run)
        && !wrCommit |=> $stable(stateReg.timer0Count))
        else $error("timer 0 moved while stopped");

    COV_T2_CAPTURE: cover property (clkEn && extTrig && stateReg.timer2Control[`T2C_CAPTURE]);
    COV_T2_RELOAD: cover property (clkEn && ovf2 && !baudMode);
    COV_SPLIT_HIGH: cover property (clkEn && highOvf);
    COV_MODE0_OVF: cover property (clkEn && mode0 == MODE_13BIT && setFlag0);

endmodule // timer_counter_unit
`default_nettype wire

//--- sim/pin_model.sv
// partner model: external count, gate and trigger pins of the timer unit
`default_nettype none
module pin_model
    import tcu_pkg::*;
(
    // clock
    input  wire logic core_clk,
    // pins toward the unit
    output var timer_pins_type pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // pins idle high, as if pulled up
    initial pins = '1;
    // one falling edge on a pin, held low for two cycles
    task automatic fall(input int b);
        @(posedge core_clk) pins[b] <= 1'b0;
        repeat (2) @(posedge core_clk);
        pins[b] <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask
    // gate level for timer 0
    task automatic gate0(input logic v);
        @(posedge core_clk) pins.extInterruptZeroPin <= v;
    endtask
endmodule // pin_model
`default_nettype wire

//--- sim/tb_top.sv
// self-checking testbench of the timer/counter unit
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top
    import tcu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, reset = 1'b1;
    apb_req_type apbReq = '0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic clkEn = 1'b1;
    logic t0Flag, t1Flag, t2Flag, extFlag;
    timer_pins_type pinsIn;
    int errors = 0, n_compared = 0;
    logic [7:0] q;
    logic e;
    always #10 core_clk = ~core_clk;
    pin_model u_pins (.core_clk(core_clk), .pins(pinsIn));
    timer_counter_unit u_dut (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
        .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pinsIn(pinsIn), .timer0OverflowFlag(t0Flag), .timer1OverflowFlag(t1Flag),
        .timer2OverflowFlag(t2Flag), .timer2ExternalFlag(extFlag));
    // ==========================================================
    // apb master: setup, access until pready, then release
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge core_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w,
                    paddr: {2'b00, i, 2'b00}, pwdata: {24'h0000, d}};
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        apbReq <= '0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d); apb(1'b1, i, d); endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] x);
        apb(1'b0, i, 8'h00);
        `CHK(q, x)
    endtask
    // ==========================================================
    // verdict
    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================================
    // timers 0 and 1
    task automatic t_t01;
        for (int m = 0; m < 2; m++) begin
            wr(8'h89, m[7:0]); wr(8'h8C, 8'hFF); wr(8'h8A, 8'h1E); wr(8'h88, 8'h00);
            wr(8'h88, 8'h10); repeat (10) @(posedge core_clk);
            rdc(8'h88, m ? 8'h10 : 8'h30);
            `CHK(t0Flag, m == 0)
            wr(8'h88, 8'h00);
            rdc(8'h8C, m ? 8'hFF : 8'h00);
            rdc(8'h8A, m ? 8'h2E : 8'h0E);
        end
        wr(8'h89, 8'h02); wr(8'h8C, 8'hF0); wr(8'h8A, 8'hFE); wr(8'h88, 8'h10);
        repeat (30) @(posedge core_clk);
        rdc(8'h88, 8'h30);
        wr(8'h88, 8'h00);
        rdc(8'h8C, 8'hF0);
        rdc(8'h8A, 8'hF2);
        u_pins.gate0(1'b0); wr(8'h89, 8'h09); wr(8'h8A, 8'h00); wr(8'h88, 8'h10);
        repeat (20) @(posedge core_clk); wr(8'h88, 8'h00); u_pins.gate0(1'b1);
        rdc(8'h8A, 8'h00);
        wr(8'h89, 8'h05); wr(8'h8A, 8'h00); wr(8'h88, 8'h10);
        u_pins.fall(0); u_pins.fall(0); wr(8'h88, 8'h00);
        rdc(8'h8A, 8'h02);
        wr(8'h89, 8'h33); wr(8'h8B, 8'h00); wr(8'h8C, 8'hFE); wr(8'h88, 8'h40);
        repeat (10) @(posedge core_clk);
        rdc(8'h88, 8'hC0);
        `CHK(t1Flag, 1'b1)
        rdc(8'h8B, 8'h00);
        wr(8'h88, 8'h00);
        $display("test timers 0 and 1 done");
    endtask
    // ==========================================================
    // timer 2 trigger, counter input, overflow and baud mode
    task automatic t_t2;
        wr(8'h8D, 8'h12); wr(8'hCD, 8'h12); wr(8'hCC, 8'h34); wr(8'hC8, 8'h09); u_pins.fall(3);
        rdc(8'hCA, 8'h34);
        rdc(8'hCB, 8'h12);
        rdc(8'hC8, 8'h49);
        `CHK(extFlag, 1'b1)
        wr(8'hC8, 8'h08); wr(8'hCA, 8'hCD); wr(8'hCB, 8'hAB); wr(8'hCD, 8'h00); u_pins.fall(3);
        rdc(8'hCC, 8'hCD);
        rdc(8'hCD, 8'hAB);
        wr(8'hC8, 8'h00); wr(8'hCC, 8'h11); u_pins.fall(3);
        rdc(8'hCC, 8'h11);
        rdc(8'hC8, 8'h00);
        wr(8'hC8, 8'h06); wr(8'hCC, 8'h00); u_pins.fall(2); u_pins.fall(2); wr(8'hC8, 8'h00);
        rdc(8'hCC, 8'h02);
        for (int b = 0; b < 2; b++) begin
            wr(8'hCD, 8'hFF); wr(8'hCC, 8'hF0); wr(8'hC8, b ? 8'h15 : 8'h05);
            repeat (40) @(posedge core_clk);
            rdc(8'hC8, b ? 8'h15 : 8'h85);
            `CHK(t2Flag, b == 0)
            wr(8'hC8, b ? 8'h10 : 8'h00);
            rdc(8'hCD, b ? 8'hAB : 8'h00);
        end
        wr(8'hCC, 8'h00); wr(8'hC8, 8'h04);
        @(posedge core_clk) clkEn <= 1'b0;
        repeat (20) @(posedge core_clk);
        clkEn <= 1'b1;
        wr(8'hC8, 8'h00);
        rdc(8'hCC, 8'h04);
        $display("test timer 2 done");
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        for (int k = 0; k < 4; k++) rdc(8'h8A + k[7:0], 8'h00);
        apb(1'b0, 8'h90, 8'h00);
        `CHK(e, 1'b1)
        $display("test reset and bus done");
        t_t01();
        t_t2();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        close_out();
    end
endmodule // tb_top
`default_nettype wire
